// ### dv/codec_slot_model.sv
// codec port slot timing model: slot start, then byte ticks
`timescale 1ns/1ps
`default_nettype none
module codec_slot_model (
    input wire logic clk_i,
    output var dma_slot_pkg::slot_evt_t evt_o
);
    initial evt_o = '0;
    // tick count above any budget, so the block must stop by itself
    task automatic run(input logic [3:0] n, input int t);
        @(posedge clk_i);
        evt_o <= '{slot_start: 1'b1, slot_num: n, byte_tick: 1'b0};
        repeat (t) begin
            @(posedge clk_i);
            evt_o <= '{slot_start: 1'b0, slot_num: n, byte_tick: 1'b1};
        end
        @(posedge clk_i);
        evt_o <= '0;
    endtask
endmodule
`default_nettype wire

// ### dv/dma_slot_asserts.sv
// checker for register access and per-slot byte pacing
`timescale 1ns/1ps
`default_nettype none
module dma_slot_asserts (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire dma_slot_pkg::mcu_req_t mcu_req_i,
    input wire logic [7:0] mcu_rdata_o,
    input wire dma_slot_pkg::slot_evt_t slot_evt_i,
    input wire logic [1:0] ch_slot_active_o,
    input wire logic [1:0] ch_byte_req_o
);
    logic mapped;
    assign mapped = mcu_req_i.addr inside
        {16'hffe9, 16'hffea, 16'hffef, 16'hfff0};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    unmapped_read_a: assert property (
        mcu_req_i.rd && !mapped |=> mcu_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (
        !mcu_req_i.rd |=> $stable(mcu_rdata_o))
        else $error("read data moved without read");
    write_read_a: assert property (
        mcu_req_i.wr && mapped ##1 mcu_req_i.rd && !mcu_req_i.wr &&
        mcu_req_i.addr == $past(mcu_req_i.addr)
        |=> mcu_rdata_o == $past(mcu_req_i.wdata, 2))
        else $error("read back differs from write");
    active_cause_a: assert property (
        $rose(ch_slot_active_o[0]) || $rose(ch_slot_active_o[1])
        |-> $past(slot_evt_i.slot_start))
        else $error("slot active without slot start");
    active_hold_a: assert property (
        !slot_evt_i.slot_start |=> $stable(ch_slot_active_o))
        else $error("slot active changed mid slot");
    high_slot_a: assert property (
        slot_evt_i.slot_start && slot_evt_i.slot_num > 4'hd
        |=> ch_slot_active_o == 2'h0)
        else $error("slot above 13 served");
    byte_cause_a: assert property (
        |ch_byte_req_o |-> $past(slot_evt_i.byte_tick) &&
        ($past(ch_slot_active_o) & ch_byte_req_o) == ch_byte_req_o)
        else $error("byte moved outside assigned slot");
    byte_limit_a: assert property (
        ch_byte_req_o[0] [*4] |=> !ch_byte_req_o[0])
        else $error("more than four bytes in a slot");
    byte_limit1_a: assert property (
        ch_byte_req_o[1] [*4] |=> !ch_byte_req_o[1])
        else $error("more than four bytes in a channel one slot");
endmodule
bind dma_slot_assignment dma_slot_asserts dma_slot_asserts_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .mcu_req_i(mcu_req_i),
    .mcu_rdata_o(mcu_rdata_o), .slot_evt_i(slot_evt_i),
    .ch_slot_active_o(ch_slot_active_o), .ch_byte_req_o(ch_byte_req_o));
`default_nettype wire

// ### dv/tb_dma_slot_assignment.sv
// self-checking bench for the dma slot assignment block
`timescale 1ns/1ps
`default_nettype none
module tb_dma_slot_assignment;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    dma_slot_pkg::mcu_req_t req = '0;
    dma_slot_pkg::slot_evt_t evt;
    logic [7:0] rdata;
    logic [1:0] act, breq;
    int miscompares = 0, n_compared = 0, c0, c1;
    logic [15:0] ad [5] = '{16'hffea, 16'hffe9, 16'hfff0, 16'hffef, 16'hffeb};
    logic [7:0] vl [5] = '{8'h01, 8'h60, 8'h82, 8'hc1, 8'h5a};
    dma_slot_assignment dma_slot_assignment_inst (.clk_i(clk_i),
        .nrst_i(nrst_i), .mcu_req_i(req), .mcu_rdata_o(rdata),
        .slot_evt_i(evt), .ch_slot_active_o(act), .ch_byte_req_o(breq));
    codec_slot_model codec_slot_model_inst (.clk_i(clk_i), .evt_o(evt));
    initial forever #4 clk_i = ~clk_i;
    always @(negedge clk_i) begin
        c0 += breq[0];
        c1 += breq[1];
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input int i, input logic [7:0] e);
        @(posedge clk_i);
        req <= '{wr: w, rd: !w, addr: ad[i], wdata: vl[i]};
        @(posedge clk_i);
        req <= '0;
        @(negedge clk_i);
        if (!w) cmp(rdata, e);
    endtask
    // write, then read the same register on the very next edge
    task automatic wrrd(input int i, input logic [7:0] e);
        @(posedge clk_i);
        req <= '{wr: 1'b1, rd: 1'b0, addr: ad[i], wdata: vl[i]};
        @(posedge clk_i);
        req <= '{wr: 1'b0, rd: 1'b1, addr: ad[i], wdata: vl[i]};
        @(posedge clk_i);
        req <= '0;
        @(negedge clk_i);
        cmp(rdata, e);
    endtask
    // ticks always outnumber the budget, so overrun shows as a count
    task automatic slot(input logic [3:0] n, input logic [7:0] e0, e1);
        @(negedge clk_i);
        c0 = 0;
        c1 = 0;
        codec_slot_model_inst.run(n, 5);
        repeat (3) @(negedge clk_i);
        cmp(c0[7:0], e0);
        cmp(c1[7:0], e1);
        cmp({6'h0, act}, {6'h0, e1 != 0, e0 != 0});
    endtask
    task automatic summarize();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #20000;
        miscompares++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 5; i++) acc(1'b0, i, 8'h00);
        for (int i = 0; i < 5; i++) acc(1'b1, i, 8'h00);
        for (int i = 0; i < 5; i++) acc(1'b0, i, i < 4 ? vl[i] : 8'h00);
        slot(4'h0, 8'h02, 8'h00);
        slot(4'h1, 8'h00, 8'h04);
        slot(4'h7, 8'h00, 8'h04);
        slot(4'h8, 8'h00, 8'h04);
        slot(4'hd, 8'h02, 8'h00);
        slot(4'h2, 8'h00, 8'h00);
        slot(4'he, 8'h00, 8'h00);
        vl[1] = 8'h20;
        vl[3] = 8'h81;
        acc(1'b1, 1, 8'h00);
        acc(1'b1, 3, 8'h00);
        slot(4'hd, 8'h01, 8'h00);
        slot(4'h8, 8'h00, 8'h03);
        vl[1] = 8'he0;
        wrrd(1, 8'he0);
        slot(4'hd, 8'h04, 8'h00);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 4; i++) acc(1'b0, i, 8'h00);
        slot(4'h0, 8'h00, 8'h00);
        summarize();
    end
endmodule
`default_nettype wire

// ### verilog/dma_slot_assignment.sv
// two-channel dma slot assignment registers and per-slot byte pacing
`timescale 1ns/1ps
`default_nettype none
`include "dma_slot_map.svh"
module dma_slot_assignment (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // microcontroller register access
    input wire dma_slot_pkg::mcu_req_t mcu_req_i,
    output logic [7:0] mcu_rdata_o,
    // codec port slot timing
    input wire dma_slot_pkg::slot_evt_t slot_evt_i,
    // per-channel pacing toward endpoint buffers and codec port
    output logic [1:0] ch_slot_active_o,
    output logic [1:0] ch_byte_req_o
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // one-hot register select; an unmapped address selects nothing, so
    // writes there are dropped and reads return the unmapped value
    function automatic logic [3:0] reg_sel(input logic [15:0] addr);
        unique case (addr)
            `CH0_SLOT_SELECT_LOW_ADDR: reg_sel = `SEL_CH0_LOW;
            `CH0_SLOT_SELECT_HIGH_ADDR: reg_sel = `SEL_CH0_HIGH;
            `CH1_SLOT_SELECT_LOW_ADDR: reg_sel = `SEL_CH1_LOW;
            `CH1_SLOT_SELECT_HIGH_ADDR: reg_sel = `SEL_CH1_HIGH;
            default: reg_sel = `SEL_NONE;
        endcase
    endfunction

    logic [3:0] wr_sel;
    logic [3:0] rd_sel;
    assign wr_sel = mcu_req_i.wr ? reg_sel(mcu_req_i.addr) : `SEL_NONE;
    assign rd_sel = reg_sel(mcu_req_i.addr);

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    // each channel keeps its own low and high byte
    logic [7:0] slot_low_ff [2];
    logic [7:0] slot_high_ff [2];

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            slot_low_ff[0] <= `SLOT_REG_RESET;
            slot_low_ff[1] <= `SLOT_REG_RESET;
            slot_high_ff[0] <= `SLOT_REG_RESET;
            slot_high_ff[1] <= `SLOT_REG_RESET;
        end else begin
            unique case (wr_sel)
                `SEL_CH0_LOW: begin
                    slot_low_ff[0] <= mcu_req_i.wdata;
                end
                `SEL_CH0_HIGH: begin
                    slot_high_ff[0] <= mcu_req_i.wdata;
                end
                `SEL_CH1_LOW: begin
                    slot_low_ff[1] <= mcu_req_i.wdata;
                end
                `SEL_CH1_HIGH: begin
                    slot_high_ff[1] <= mcu_req_i.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // read data is registered; the mcu samples it one cycle after rd
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mcu_rdata_o <= `UNMAPPED_READ;
        end else if (mcu_req_i.rd) begin
            unique case (rd_sel)
                `SEL_CH0_LOW: mcu_rdata_o <= slot_low_ff[0];
                `SEL_CH0_HIGH: mcu_rdata_o <= slot_high_ff[0];
                `SEL_CH1_LOW: mcu_rdata_o <= slot_low_ff[1];
                `SEL_CH1_HIGH: mcu_rdata_o <= slot_high_ff[1];
                default: mcu_rdata_o <= `UNMAPPED_READ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    // fourteen-bit slot mask of one channel
    function automatic logic [13:0] slot_mask(input logic [7:0] hi,
                                              input logic [7:0] lo);
        slot_mask = {hi[`HIGH_SLOT_MSB:`HIGH_SLOT_LSB], lo};
    endfunction

    // field code n means n+1 bytes per slot
    function automatic logic [2:0] byte_budget(input logic [7:0] hi);
        byte_budget = {1'b0, hi[`BYTES_PER_SLOT_MSB:`BYTES_PER_SLOT_LSB]}
                      + `BYTE_COUNT_ONE;
    endfunction

    // slot numbers 14 and 15 never match, so stray codes move nothing
    function automatic logic slot_hit(input logic [13:0] mask,
                                      input logic [3:0] num);
        slot_hit = (num < 4'(`NUM_SLOTS)) && mask[num];
    endfunction

    // ----------------------------------------------------------------
    // per-channel byte pacing
    // ----------------------------------------------------------------
    dma_slot_pkg::ch_state_t state_ff [`NUM_CHANNELS];
    dma_slot_pkg::ch_state_t nxt_state [`NUM_CHANNELS];
    logic [2:0] left_ff [`NUM_CHANNELS];
    logic [2:0] nxt_left [`NUM_CHANNELS];
    logic [1:0] hit;
    logic [1:0] nxt_byte_req;
    logic [1:0] nxt_slot_active;

    // slot match of each channel; the mask is rebuilt every cycle, so a
    // register write counts from the next slot start on
    always_comb begin
        for (int c = 0; c < `NUM_CHANNELS; c++) begin
            hit[c] = slot_hit(slot_mask(slot_high_ff[c], slot_low_ff[c]),
                              slot_evt_i.slot_num);
        end
    end

    // a new slot start always ends the previous slot's transfer,
    // so a short slot can never leak bytes into the next one
    always_comb begin
        for (int c = 0; c < `NUM_CHANNELS; c++) begin
            nxt_state[c] = state_ff[c];
            nxt_left[c] = left_ff[c];
            if (slot_evt_i.slot_start) begin
                if (hit[c]) begin
                    nxt_state[c] = dma_slot_pkg::CH_MOVE;
                    nxt_left[c] = byte_budget(slot_high_ff[c]);
                end else begin
                    nxt_state[c] = dma_slot_pkg::CH_IDLE;
                    nxt_left[c] = `BYTE_COUNT_ZERO;
                end
            end else begin
                unique case (state_ff[c])
                    dma_slot_pkg::CH_IDLE: begin
                    end
                    dma_slot_pkg::CH_MOVE: begin
                        if (slot_evt_i.byte_tick) begin
                            nxt_left[c] = left_ff[c] - `BYTE_COUNT_ONE;
                            if (left_ff[c] == `BYTE_COUNT_ONE) begin
                                nxt_state[c] = dma_slot_pkg::CH_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // pacing state of each channel
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int c = 0; c < `NUM_CHANNELS; c++) begin
                state_ff[c] <= dma_slot_pkg::CH_IDLE;
            end
        end else begin
            for (int c = 0; c < `NUM_CHANNELS; c++) begin
                state_ff[c] <= nxt_state[c];
            end
        end
    end

    // remaining byte budget of the current slot
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int c = 0; c < `NUM_CHANNELS; c++) begin
                left_ff[c] <= `BYTE_COUNT_ZERO;
            end
        end else begin
            for (int c = 0; c < `NUM_CHANNELS; c++) begin
                left_ff[c] <= nxt_left[c];
            end
        end
    end

    // one request per byte tick while budget remains
    always_comb begin
        for (int c = 0; c < `NUM_CHANNELS; c++) begin
            nxt_byte_req[c] = (state_ff[c] == dma_slot_pkg::CH_MOVE)
                              && slot_evt_i.byte_tick
                              && !slot_evt_i.slot_start;
        end
    end

    // active level follows the match of the latest slot start
    always_comb begin
        nxt_slot_active = ch_slot_active_o;
        if (slot_evt_i.slot_start) begin
            nxt_slot_active = hit;
        end
    end

    // byte request pulses, one cycle each
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ch_byte_req_o <= '0;
        end else begin
            ch_byte_req_o <= nxt_byte_req;
        end
    end

    // slot active level, held until the next slot start
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ch_slot_active_o <= '0;
        end else begin
            ch_slot_active_o <= nxt_slot_active;
        end
    end

endmodule
`default_nettype wire

// ### verilog/dma_slot_map.svh
// address map, field positions and reset values of the slot-assignment regs
`ifndef DMA_SLOT_MAP_SVH
`define DMA_SLOT_MAP_SVH
`define CH0_SLOT_SELECT_HIGH_ADDR 16'hffe9
`define CH0_SLOT_SELECT_LOW_ADDR 16'hffea
`define CH1_SLOT_SELECT_HIGH_ADDR 16'hffef
`define CH1_SLOT_SELECT_LOW_ADDR 16'hfff0
`define SLOT_REG_RESET 8'h00
`define UNMAPPED_READ 8'h00
`define HIGH_SLOT_MSB 5
`define HIGH_SLOT_LSB 0
`define BYTES_PER_SLOT_MSB 7
`define BYTES_PER_SLOT_LSB 6
`define NUM_SLOTS 14
`define NUM_CHANNELS 2
`define BYTE_COUNT_ZERO 3'h0
`define BYTE_COUNT_ONE 3'h1
`define SEL_NONE 4'h0
`define SEL_CH0_LOW 4'h1
`define SEL_CH0_HIGH 4'h2
`define SEL_CH1_LOW 4'h4
`define SEL_CH1_HIGH 4'h8
`endif

// ### verilog/dma_slot_pkg.sv
// types shared by the slot-assignment block and its users
package dma_slot_pkg;
    // one microcontroller access to the register space
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mcu_req_t;
    // codec-port slot timing: slot start pulse, slot number, byte strobe
    typedef struct packed {
        logic slot_start;
        logic [3:0] slot_num;
        logic byte_tick;
    } slot_evt_t;
    typedef enum logic [1:0] {
        CH_IDLE = 2'b01,
        CH_MOVE = 2'b10
    } ch_state_t;
endpackage
